/* File: pkg/ccdc_pkg.sv */
// constants for the csma/cd deferral and collision block
package ccdc_pkg;
    // ==================== timing
    localparam int CLK_NS = 25;
    localparam int BIT_NS = 100;
    localparam int BIT_DIV_I = BIT_NS / CLK_NS;
    localparam logic [1:0] BIT_DIV_LAST = 2'(BIT_DIV_I - 1);
    localparam int PART1_NS = 6000;
    localparam int PART2_NS = 3600;
    localparam int BLIND_NS = 4000;
    localparam logic [6:0] PART1_BITS = 7'((PART1_NS + BIT_NS - 1) / BIT_NS);
    localparam logic [6:0] GAP_BITS = 7'((PART1_NS + PART2_NS + BIT_NS - 1) / BIT_NS);
    localparam logic [6:0] BLIND_BITS = 7'((BLIND_NS + BIT_NS - 1) / BIT_NS);
    // ==================== frame and backoff counts
    localparam logic [5:0] PRE_LAST = 6'h3F;
    localparam logic [5:0] JAM_BITS = 6'h20;
    localparam logic [9:0] SLOT_BITS = 10'h200;
    localparam logic [8:0] SLOT_LAST = 9'h1FF;
    localparam logic [4:0] LAST_RETRY = 5'h0F;
    localparam logic [3:0] BO_KMAX = 4'hA;
    // ==================== register map
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h4;
    localparam int CTRL_TX2PD = 0;
    localparam int CTRL_RETRY_DIS = 1;
    localparam int CTRL_BO_PAUSE = 2;
    localparam int STAT_ONE = 0;
    localparam int STAT_MORE = 1;
    localparam int STAT_RETRY_FAILURE_FLAG = 2;
    localparam int STAT_LATE = 3;
    localparam int STAT_DEFER = 4;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;
    // ==================== states
    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_PRE = 5'h02,
        S_DATA = 5'h04,
        S_JAM = 5'h08,
        S_BACK = 5'h10
    } ccdc_state_t;
endpackage

/* File: rtl/ccdc_mac.sv */
// csma/cd deferral, collision handling and backoff engine
// Operation
// [R01] receive deferral: 6.0 us then 3.6 us
// [R02] gap timer times 9.6 us from carrier drop
// [R03] first part: defer, receive, hold gap at zero
// [R04] second part, pending: ignore carrier, transmit anyway
// [R05] forced collision: full preamble, jam, then backoff
// [R06] transmit two-part deferral disabled by control bit
// [R07] ignore carrier 4.0 us after own transmission
// [R08] post-transmit first part spans 4 to 6 us
// [R09] carrier at 4-6 us restarts first part, no blinding
// [R10] early collision: finish preamble and delimiter, then jam
// [R11] collision before 512 bits: jam at once
// [R12] jam is 32 zero bits
// [R13] at most 16 attempts, retry after backoff
// [R14] success sets one-retry or multiple-retry flag
// [R15] sixteen collisions: retry failure, flush frame
// [R16] retry disable: fail at first collision, flush
// [R17] late collision: jam, late flag, flush, no retry
// [R18] backoff r slots, r below 2^min(n,10)
// [R19] optional backoff pauses while carrier present
// [R20] seven preamble bytes then delimiter 10101011
// [R21] bit time 100 ns, slot 512 bits
`timescale 1ns/1ps
`default_nettype none
module ccdc_mac
    import ccdc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // medium through the manchester codec
    input wire logic carrier_sense,
    input wire logic collision,
    output logic tx_en,
    output logic tx_data,
    output logic rx_accept,
    // transmit fifo
    input wire logic tx_pending,
    input wire logic fifo_bit,
    input wire logic fifo_last,
    output logic fifo_pop,
    output logic frame_done,
    output logic fifo_flush
);
    // ==================== state
    typedef struct packed {
        ccdc_state_t st;
        logic [1:0] bdiv;
        logic [1:0] crs_sync;
        logic [1:0] col_sync;
        logic [6:0] gap;
        logic after_tx;
        logic [5:0] bcnt;
        logic [9:0] dcnt;
        logic last_out;
        logic coll_pend;
        logic late;
        logic [4:0] retries;
        logic [9:0] bo_slots;
        logic [8:0] bo_bits;
        logic [15:0] lfsr;
        logic [2:0] ctrl;
        logic [4:0] stat;
        logic tx_en;
        logic tx_data;
        logic fifo_pop;
        logic frame_done;
        logic fifo_flush;
        logic rx_accept;
        logic [31:0] rdata;
    } ccdc_regs_t;

    ccdc_regs_t q;
    ccdc_regs_t next_q;
    logic tick;
    logic crs;
    logic col;
    logic deaf;
    logic crs_eff;
    logic gap_done;
    logic tx_busy;
    logic [3:0] bo_k;
    logic [9:0] bo_mask;

    assign reg_rdata = q.rdata;
    assign tx_en = q.tx_en;
    assign tx_data = q.tx_data;
    assign rx_accept = q.rx_accept;
    assign fifo_pop = q.fifo_pop;
    assign frame_done = q.frame_done;
    assign fifo_flush = q.fifo_flush;

    // ==================== next state
    always_comb begin
        next_q = q;
        next_q.fifo_pop = 1'b0;
        next_q.frame_done = 1'b0;
        next_q.fifo_flush = 1'b0;
        next_q.rdata = 32'h0000_0000;
        // pins come from the codec domain, so two flops first
        next_q.crs_sync = {q.crs_sync[0], carrier_sense};
        next_q.col_sync = {q.col_sync[0], collision};
        crs = q.crs_sync[1];
        col = q.col_sync[1];
        next_q.lfsr = {q.lfsr[14:0], q.lfsr[15] ^ q.lfsr[13] ^ q.lfsr[12] ^ q.lfsr[10]};
        // one bit time every four clocks
        tick = (q.bdiv == BIT_DIV_LAST); // [R21]
        next_q.bdiv = tick ? 2'h0 : q.bdiv + 2'h1;

        // ==================== register port
        if (reg_wr) begin
            if (reg_addr == REG_CTRL) begin
                next_q.ctrl = reg_wdata[2:0];
            end
        end
        if (reg_rd) begin
            if (reg_addr == REG_CTRL) begin
                next_q.rdata = {29'h0, q.ctrl};
            end else if (reg_addr == REG_STAT) begin
                next_q.rdata = {27'h0, q.stat};
            end else begin
                next_q.rdata = 32'h0000_0000;
            end
        end

        // ==================== deferral
        // blinding covers the sqe test burst after our own frame
        deaf = q.after_tx && !q.ctrl[CTRL_TX2PD] && (q.gap < BLIND_BITS); // [R07] [R08]
        // once past the first part a pending frame wins the medium
        if (tx_pending && (q.gap >= PART1_BITS)) begin
            deaf = 1'b1; // [R04] [R01]
        end
        // disabled: one uninterruptible part after our own frame
        if (tx_pending && q.after_tx && q.ctrl[CTRL_TX2PD]) begin
            deaf = 1'b1; // [R06]
        end
        crs_eff = crs && !deaf;
        gap_done = (q.gap == GAP_BITS);
        tx_busy = (q.st == S_PRE) || (q.st == S_DATA) || (q.st == S_JAM);
        next_q.rx_accept = crs_eff && !tx_busy; // [R03]
        if (tx_busy) begin
            next_q.gap = 7'h00;
        end else if (crs_eff) begin
            // restart of the whole first part, blinding not re-armed
            next_q.gap = 7'h00; // [R03] [R09]
            next_q.after_tx = 1'b0; // [R09]
        end else if (tick && !gap_done) begin
            next_q.gap = q.gap + 7'h01; // [R02]
        end

        // ==================== backoff window
        bo_k = (q.retries + 5'h01 > 5'(BO_KMAX)) ? BO_KMAX : 4'(q.retries + 5'h01);
        bo_mask = 10'((11'h001 << bo_k) - 11'h001); // [R18]

        // ==================== transmit sequencer
        case (q.st)
            S_IDLE: begin
                next_q.tx_en = 1'b0;
                next_q.tx_data = 1'b0;
                if (tx_pending && q.retries == 5'h00 && !gap_done) begin
                    next_q.stat[STAT_DEFER] = 1'b1;
                end
                if (tick && tx_pending && gap_done && !crs_eff) begin
                    next_q.st = S_PRE;
                    next_q.tx_en = 1'b1;
                    next_q.tx_data = 1'b1; // [R20]
                    next_q.bcnt = 6'h01;
                    next_q.dcnt = 10'h000;
                    next_q.coll_pend = 1'b0;
                    next_q.late = 1'b0;
                    next_q.last_out = 1'b0;
                    if (q.retries == 5'h00) begin
                        next_q.stat = {q.stat[STAT_DEFER], 4'h0};
                    end
                end
            end
            S_PRE: begin
                if (col) begin
                    next_q.coll_pend = 1'b1; // [R10] [R05]
                end
                if (tick) begin
                    if (q.bcnt == PRE_LAST) begin
                        next_q.st = (q.coll_pend || col) ? S_JAM : S_DATA; // [R10]
                        next_q.bcnt = 6'h00;
                    end else begin
                        next_q.bcnt = q.bcnt + 6'h01;
                    end
                    // alternating ones and zeros, delimiter ends in two ones
                    next_q.tx_data = ~q.bcnt[0] | (q.bcnt == PRE_LAST); // [R20]
                end
            end
            S_DATA: begin
                if (col && !q.last_out) begin
                    // jam starts on the next bit, frame data abandoned
                    next_q.st = S_JAM; // [R11]
                    next_q.bcnt = 6'h00;
                    next_q.late = (q.dcnt >= SLOT_BITS); // [R17]
                end else if (tick) begin
                    if (q.last_out) begin
                        next_q.st = S_IDLE;
                        next_q.tx_en = 1'b0;
                        next_q.tx_data = 1'b0;
                        next_q.after_tx = 1'b1;
                        next_q.frame_done = 1'b1;
                        next_q.stat[STAT_ONE] = (q.retries == 5'h01); // [R14]
                        next_q.stat[STAT_MORE] = (q.retries > 5'h01); // [R14]
                        next_q.retries = 5'h00;
                    end else begin
                        next_q.tx_data = fifo_bit;
                        next_q.fifo_pop = 1'b1;
                        next_q.last_out = fifo_last;
                        if (q.dcnt < SLOT_BITS) begin
                            next_q.dcnt = q.dcnt + 10'h001;
                        end
                    end
                end
            end
            S_JAM: begin
                if (tick) begin
                    if (q.bcnt == JAM_BITS) begin
                        next_q.tx_en = 1'b0;
                        next_q.tx_data = 1'b0;
                        next_q.after_tx = 1'b1;
                        next_q.st = S_IDLE;
                        if (q.late) begin
                            next_q.stat[STAT_LATE] = 1'b1; // [R17]
                            next_q.fifo_flush = 1'b1;
                            next_q.retries = 5'h00;
                        end else if (q.ctrl[CTRL_RETRY_DIS] || q.retries == LAST_RETRY) begin
                            next_q.stat[STAT_RETRY_FAILURE_FLAG] = 1'b1; // [R15] [R16]
                            next_q.stat[STAT_ONE] = 1'b0;
                            next_q.stat[STAT_MORE] = 1'b0;
                            next_q.fifo_flush = 1'b1;
                            next_q.retries = 5'h00;
                        end else begin
                            next_q.retries = q.retries + 5'h01; // [R13]
                            next_q.bo_slots = q.lfsr[9:0] & bo_mask; // [R18]
                            next_q.bo_bits = 9'h000;
                            next_q.st = S_BACK; // [R05]
                        end
                    end else begin
                        next_q.tx_data = 1'b0; // [R12]
                        next_q.bcnt = q.bcnt + 6'h01;
                    end
                end
            end
            S_BACK: begin
                // the pausing mode lets quiet stations in first on a busy wire
                if (tick && !(q.ctrl[CTRL_BO_PAUSE] && crs)) begin // [R19]
                    if (q.bo_slots == 10'h000) begin
                        next_q.st = S_IDLE; // [R13]
                    end else if (q.bo_bits == SLOT_LAST) begin
                        next_q.bo_bits = 9'h000; // [R21]
                        next_q.bo_slots = q.bo_slots - 10'h001;
                    end else begin
                        next_q.bo_bits = q.bo_bits + 9'h001;
                    end
                end
            end
            default: begin
                next_q.st = S_IDLE;
            end
        endcase
    end

    // ==================== registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.st <= S_IDLE;
            q.gap <= GAP_BITS;
            q.lfsr <= LFSR_SEED;
            q.ctrl <= CTRL_RST;
        end else begin
            q <= next_q;
        end
    end

    // ==================== checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_pre_end;
        q.st == S_PRE && tick && q.bcnt == PRE_LAST;
    endsequence
    sequence s_jam_end;
        q.st == S_JAM && tick && q.bcnt == JAM_BITS;
    endsequence

    property p_jam_zero;
        (q.st == S_JAM && q.bcnt != 6'h00) |-> !q.tx_data;
    endproperty
    a_jam_zero: assert property (p_jam_zero) else $error("jam bit not zero"); // [R12]

    property p_jam_len;
        s_jam_end |=> !q.tx_en;
    endproperty
    a_jam_len: assert property (p_jam_len) else $error("jam did not end"); // [R12]

    property p_jam_hold;
        (q.st == S_JAM && q.bcnt < JAM_BITS) |=> q.tx_en && q.st == S_JAM;
    endproperty
    a_jam_hold: assert property (p_jam_hold) else $error("jam cut short"); // [R05]

    property p_pre_complete;
        (q.st == S_PRE) |=> (q.st == S_PRE || $past(q.bcnt) == PRE_LAST);
    endproperty
    a_pre_complete: assert property (p_pre_complete) else $error("preamble cut"); // [R10]

    property p_sfd_tail;
        s_pre_end |=> q.tx_data && q.tx_en;
    endproperty
    a_sfd_tail: assert property (p_sfd_tail) else $error("delimiter end bit wrong"); // [R20]

    property p_start_gap;
        $rose(q.tx_en) |-> $past(q.gap) == GAP_BITS;
    endproperty
    a_start_gap: assert property (p_start_gap) else $error("sent before gap"); // [R02]

    property p_part1_reset;
        (q.st == S_IDLE && crs && !q.after_tx && q.gap < PART1_BITS) |=> q.gap == 7'h00;
    endproperty
    a_part1_reset: assert property (p_part1_reset) else $error("gap not cleared"); // [R03]

    // carrier seen while deaf must never pull the gap back to zero
    property p_blind;
        (q.st == S_IDLE && deaf && crs && q.gap != 7'h00) |=> q.gap != 7'h00;
    endproperty
    a_blind: assert property (p_blind) else $error("carrier heard while deaf"); // [R07]

    property p_late;
        (q.st == S_DATA && col && !q.last_out && q.dcnt >= SLOT_BITS) |=> q.late;
    endproperty
    a_late: assert property (p_late) else $error("late collision missed"); // [R17]

    property p_fail_flags;
        (q.fifo_flush && q.stat[STAT_RETRY_FAILURE_FLAG]) |-> !q.stat[STAT_ONE] && !q.stat[STAT_MORE];
    endproperty
    a_fail_flags: assert property (p_fail_flags) else $error("retry flags on failure"); // [R15]

    property p_retry_dis;
        (s_jam_end and (q.ctrl[CTRL_RETRY_DIS] && !q.late)) |=> q.fifo_flush && q.st == S_IDLE;
    endproperty
    a_retry_dis: assert property (p_retry_dis) else $error("retried while disabled"); // [R16]

    property p_bo_pause;
        (q.st == S_BACK && q.ctrl[CTRL_BO_PAUSE] && crs) |=> $stable(q.bo_slots) && $stable(q.bo_bits);
    endproperty
    a_bo_pause: assert property (p_bo_pause) else $error("backoff ran under carrier"); // [R19]
endmodule
`default_nettype wire

/* File: verification/ccdc_mac_tb.sv */
// self-checking bench for the deferral and collision engine
`timescale 1ns/1ps
`default_nettype none
module ccdc_mac_tb;
    import ccdc_pkg::*;
    // ==================== signals
    localparam int WLO = 380;
    localparam int WHI = 400;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic carrier_sense, collision, tx_en, tx_data, rx_accept;
    logic fifo_pop, frame_done, fifo_flush, fifo_bit, fifo_last;
    logic tx_pending = 1'b0;
    logic carrier_req = 1'b0;
    logic [15:0] coll_bit = 16'hFFFF;
    logic [4:0] coll_cnt = 5'h0;
    logic tx_q = 1'b0;
    logic a;
    logic [31:0] v;
    logic bq[$];
    int fail_count = 0, cmp_count = 0, cyc = 0, t_rise = 0, t_fall = 0, t0 = 0;
    int tc = 0, idx = 0, len = 16, n_rise = 0, n_end = 0, n_flush = 0;
    assign fifo_bit = idx[0] ^ idx[2];
    assign fifo_last = (idx == len - 1);
    always #12.5 ref_clk = ~ref_clk;
    ccdc_mac ccdc_mac_i (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .carrier_sense(carrier_sense), .collision(collision), .tx_en(tx_en),
        .tx_data(tx_data), .rx_accept(rx_accept), .tx_pending(tx_pending),
        .fifo_bit(fifo_bit), .fifo_last(fifo_last), .fifo_pop(fifo_pop),
        .frame_done(frame_done), .fifo_flush(fifo_flush));
    ccdc_medium ccdc_medium_i (.ref_clk(ref_clk), .carrier_req(carrier_req),
        .coll_bit(coll_bit), .coll_cnt(coll_cnt), .tx_en(tx_en),
        .carrier_sense(carrier_sense), .collision(collision));
    // ==================== monitor and fifo feed
    always @(posedge ref_clk) begin
        cyc++;
        if (fifo_pop) idx <= idx + 1;
        if (tx_en && !tx_q) begin
            t_rise = cyc;
            n_rise++;
            tc = 0;
            bq.delete();
            idx <= 0;
        end
        // sample mid-bit, tx_data moves every 4 clocks
        if (tx_en) begin
            if (tc % 4 == 1) bq.push_back(tx_data);
            tc++;
        end
        if (!tx_en && tx_q) t_fall = cyc;
        tx_q = tx_en;
        n_end += frame_done + fifo_flush;
        n_flush += fifo_flush;
    end
    // ==================== tasks
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wr(input logic [3:0] ad, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] ad);
        @(posedge ref_clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        v = reg_rdata;
    endtask
    task chk_stat(input logic [31:0] e);
        rd(REG_STAT);
        chk("status", v & 32'h0F, e);
    endtask
    task launch(input int l, input logic [4:0] cc, input logic [15:0] cb);
        @(posedge ref_clk);
        coll_cnt <= 5'h0;
        @(posedge ref_clk);
        len <= l;
        coll_cnt <= cc;
        coll_bit <= cb;
        tx_pending <= 1'b1;
    endtask
    task wait_rise(input int lim);
        int n0;
        n0 = n_rise;
        repeat (lim) begin
            @(negedge ref_clk);
            if (n_rise != n0) return;
        end
        chk("tx start", 0, 1);
    endtask
    task wait_fall(input int lim);
        repeat (lim) begin
            @(negedge ref_clk);
            if (!tx_en) begin
                @(negedge ref_clk);
                return;
            end
        end
        chk("tx stop", 0, 1);
    endtask
    task wait_end(input int lim);
        int n0;
        n0 = n_end;
        repeat (lim) begin
            @(negedge ref_clk);
            if (n_end != n0) begin
                @(posedge ref_clk);
                tx_pending <= 1'b0;
                wait_fall(20);
                return;
            end
        end
        chk("frame end", 0, 1);
    endtask
    task cpulse(input int n);
        @(posedge ref_clk);
        carrier_req <= 1'b1;
        repeat (n - 1) @(posedge ref_clk);
        @(negedge ref_clk);
        a = rx_accept;
        @(posedge ref_clk);
        carrier_req <= 1'b0;
        @(negedge ref_clk);
        t0 = cyc;
    endtask
    task at_bit(input int b);
        while (cyc - t_fall < b * 4) @(posedge ref_clk);
    endtask
    task pcheck;
        for (int k = 0; k < 64; k++) chk("preamble", 32'(bq[k]), 32'(k == 63 || !k[0]));
    endtask
    task dcheck(input int d);
        for (int k = 0; k < d; k++) chk("data", 32'(bq[64 + k]), 32'(k[0] ^ k[2]));
    endtask
    task fcheck(input int d);
        chk("bits", 32'(bq.size() >= 64 + d && bq.size() <= 66 + d), 1);
        pcheck();
        dcheck(d);
    endtask
    task jcheck(input int lo, input int hi);
        chk("jam len", 32'(bq.size() >= lo && bq.size() <= hi), 1);
        for (int k = bq.size() - 32; k < bq.size(); k++) chk("jam", 32'(bq[k]), 0);
    endtask
    task boff(input int k);
        int dd;
        dd = t_rise - t_fall;
        chk("backoff slots", 32'(dd / 2048 < (1 << k)), 1);
        chk("slot align", 32'(dd < 2048 ? dd >= WLO && dd <= WHI : dd % 2048 < 20), 1);
    endtask
    task tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ==================== watchdog, expected run stays below 25000 cycles
    initial begin
        repeat (80000) @(posedge ref_clk);
        chk("watchdog", 0, 1);
        tally_and_finish();
    end
    // ==================== tests
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(REG_CTRL);
        chk("ctrl reset", v, 32'h0);
        chk_stat(32'h0);
        wr(REG_STAT, 32'hFF);
        chk_stat(32'h0);
        rd(4'h8);
        chk("unmapped", v, 32'h0);
        wr(REG_CTRL, 32'h7);
        rd(REG_CTRL);
        chk("ctrl rw", v, 32'h7);
        wr(REG_CTRL, 32'h0);
        launch(16, 5'h0, 16'hFFFF);
        wait_end(2000);
        fcheck(16);
        chk_stat(32'h0);
        $display("test regs and plain frame done");
        repeat (400) @(posedge ref_clk);
        cpulse(200);
        chk("rx accept", 32'(a), 1);
        repeat (120) @(posedge ref_clk);
        cpulse(20);
        chk("rx accept restart", 32'(a), 1);
        launch(16, 5'h0, 16'hFFFF);
        wait_rise(600);
        chk("gap", 32'(t_rise - t0 >= WLO && t_rise - t0 <= WHI), 1);
        wait_end(2000);
        fcheck(16);
        $display("test receive deferral done");
        // pausing backoff on: this jam ends under remote carrier
        wr(REG_CTRL, 32'h4);
        repeat (400) @(posedge ref_clk);
        cpulse(100);
        launch(16, 5'h1, 16'h0005);
        repeat (278) @(posedge ref_clk);
        carrier_req <= 1'b1;
        repeat (20) @(negedge ref_clk);
        chk("rx deaf", 32'(rx_accept), 0);
        wait_rise(300);
        chk("forced start", 32'(t_rise - t0 >= WLO && t_rise - t0 <= WHI), 1);
        wait_fall(600);
        @(posedge ref_clk);
        carrier_req <= 1'b0;
        pcheck();
        jcheck(96, 98);
        wait_rise(2600);
        boff(1);
        wait_end(2000);
        fcheck(16);
        chk_stat(32'h1);
        $display("test forced collision done");
        repeat (400) @(posedge ref_clk);
        launch(40, 5'h2, 16'd80);
        wait_rise(600);
        for (int k = 1; k <= 2; k++) begin
            wait_fall(1000);
            dcheck(16);
            jcheck(112, 122);
            wait_rise(9000);
            boff(k);
        end
        wait_end(3000);
        fcheck(40);
        chk_stat(32'h2);
        $display("test data collision retries done");
        wr(REG_CTRL, 32'h2);
        repeat (400) @(posedge ref_clk);
        t0 = n_rise;
        launch(40, 5'h1, 16'd80);
        wait_end(3000);
        chk("no retry", 32'(n_rise - t0), 1);
        chk("flush", 32'(n_flush), 1);
        chk_stat(32'h4);
        wr(REG_CTRL, 32'h0);
        repeat (400) @(posedge ref_clk);
        t0 = n_rise;
        launch(600, 5'h1, 16'd584);
        wait_end(4000);
        jcheck(617, 626);
        chk("late flush", 32'(n_flush), 2);
        chk("late no retry", 32'(n_rise - t0), 1);
        chk_stat(32'h8);
        $display("test retry disable and late collision done");
        at_bit(20);
        cpulse(20);
        chk("blind", 32'(a), 0);
        at_bit(50);
        cpulse(20);
        chk("after blind", 32'(a), 1);
        launch(16, 5'h0, 16'hFFFF);
        wait_rise(600);
        chk("restart part one", 32'(t_rise - t0 >= WLO && t_rise - t0 <= WHI), 1);
        wr(REG_CTRL, 32'h1);
        wait_end(2000);
        launch(16, 5'h0, 16'hFFFF);
        at_bit(50);
        cpulse(20);
        chk("defer disabled deaf", 32'(a), 0);
        wait_rise(600);
        chk("single part", 32'(t_rise - t_fall >= WLO && t_rise - t_fall <= WHI), 1);
        wait_end(2000);
        fcheck(16);
        $display("test blinding and transmit deferral done");
        tally_and_finish();
    end
endmodule
`default_nettype wire

/* File: verification/ccdc_medium.sv */
// shared medium model: remote carrier on command, collisions against own transmission
`timescale 1ns/1ps
`default_nettype none
module ccdc_medium (
    // clock
    input wire logic ref_clk,
    // bench control
    input wire logic carrier_req,
    input wire logic [15:0] coll_bit,
    input wire logic [4:0] coll_cnt,
    // codec side
    input wire logic tx_en,
    output logic carrier_sense,
    output logic collision
);
    logic [17:0] tc = 18'h0;
    logic [4:0] hits = 5'h0;
    logic hit;
    assign carrier_sense = carrier_req;
    assign hit = hits < coll_cnt && tc[17:2] >= coll_bit;
    // a collision exists only while we drive the medium, so it drops with tx_en
    assign collision = tx_en && hit;
    always @(posedge ref_clk) begin
        tc <= tx_en ? tc + 18'h1 : 18'h0;
        if (!tx_en && tc != 18'h0 && hit) begin
            hits <= hits + 5'h1;
        end
        if (coll_cnt == 5'h0) begin
            hits <= 5'h0;
        end
    end
endmodule
`default_nettype wire
